// file: core/fesc_device.sv
// Flash erase/write steering with security lock and fuse logic
// Notes on behaviour
// - Mass erase needs enable bit then 0xAA.
// - Mass erase only while debug port enabled.
// - Page erase: load page, then write 0x55.
// - 128 pages of 512 bytes each.
// - Page select bits 7:1 give address 15:9.
// - Write enable steers stores to flash, else RAM.
// - Software disables interrupts before write enable.
// - Software sets processor clock to 0x0C first.
// - Reset fetch at 0x0000, vectors every 8.
// - Lock limits debug port to bulk erase.
// - Lock clears on reset, software only sets.
// - Lock sets only if first fuse blown.
// - Locked: page zero not page-erasable.
// - Locked: writes to page zero suppressed.
// - Global erase flags flash only; data RAM is not cleared.
// - Lock leaves on any reset, no erase needed.
// - Second fuse disables debug port, sampled at reset.
// - Pin status bit mirrors pin; fuse two needs pin high.
// - Fuse arm 0x54, then select 0x81 or 0x82.
// - Trim 0xA6, wait 500 us, clear both.
// - Program one fuse per sequence.
`include "fesc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module fesc_device #(
  parameter int ADDR_W      = 15,
  parameter int RAM_W       = 11,
  parameter int BURN_CYCLES = `FESC_BURN_CYCLES
) (
  input  wire logic              I_CLOCK,
  input  wire logic              I_RSTN,
  fesc_if.dev                    bus,
  input  wire logic              I_SECURITY_PIN,
  input  wire logic              I_DEBUG_PORT_ENABLE,
  output logic [15:0]            O_BOOT_VECTOR,
  output logic [15:0]            O_VECTOR_BASE,
  output logic                   O_DEBUG_PORT_ACTIVE,
  output logic                   O_FLASH_WE,
  output logic [ADDR_W-1:0]      O_FLASH_ADDR,
  output logic [7:0]             O_FLASH_DATA,
  output logic                   O_RAM_WE,
  output logic [RAM_W-1:0]       O_RAM_ADDR,
  output logic [7:0]             O_RAM_DATA,
  output logic                   O_ERASE_MASS,
  output logic                   O_ERASE_PAGE,
  output logic [6:0]             O_ERASE_PAGE_NUM,
  output logic [1:0]             O_FUSE_BURN
);
  fesc_pkg::fesc_erase_t state_reg, state_next;
  logic [7:0]  ctl_reg, page_reg, trim_reg, fuse_reg, fsel_reg;
  logic        lock_reg, fuse0_reg, fuse1_reg, fuse1_at_reset_reg, strap_done_reg;
  logic        pin_m_reg, pin_reg, dbg_m_reg, dbg_reg;
  logic [31:0] burn_cnt_reg;
  logic [7:0]  erase_cnt_reg;
  logic        ack_reg, dbg_ack_reg;
  logic [7:0]  rdata_reg;
  logic        flash_we_reg, ram_we_reg;
  logic [ADDR_W-1:0] flash_addr_reg;
  logic [RAM_W-1:0]  ram_addr_reg;
  logic [7:0]  flash_data_reg, ram_data_reg;

  // Debug port usable only when enabled and the second fuse was clear at reset
  wire dbg_ok      = dbg_reg & ~fuse1_at_reset_reg;
  wire cpu_wr      = bus.req & bus.wr & ~ack_reg;
  wire wr_erase    = cpu_wr && bus.addr == `FESC_OFF_ERASE_CMD;
  wire wr_ctl      = cpu_wr && bus.addr == `FESC_OFF_FLASH_CTL;
  wire wr_page     = cpu_wr && bus.addr == `FESC_OFF_PAGE_SEL;
  wire wr_trim     = cpu_wr && bus.addr == `FESC_OFF_TRIM_CTL;
  wire wr_fuse     = cpu_wr && bus.addr == `FESC_OFF_FUSE_CTL;
  wire idle        = state_reg == fesc_pkg::FESC_IDLE;
  wire page_zero   = page_reg[7:1] == 7'h00;
  wire mass_cpu    = wr_erase && bus.wdata == `FESC_PAT_MASS && ctl_reg[`FESC_BIT_MEEN]
                     && dbg_ok;
  wire mass_dbg    = bus.dbg_req & bus.dbg_mass & ~dbg_ack_reg & dbg_ok;
  wire page_go     = wr_erase && bus.wdata == `FESC_PAT_PAGE
                     && !(lock_reg && page_zero);
  // Locked debug port may do nothing but bulk erase
  wire dbg_wr_ok   = bus.dbg_req & bus.dbg_wr & ~bus.dbg_mass & ~dbg_ack_reg
                     & dbg_ok & ~lock_reg;
  wire [15:0] st_addr = dbg_wr_ok ? bus.dbg_addr : bus.ext_addr;
  wire st_page0    = st_addr[15:9] == 7'h00;
  wire to_flash    = (dbg_wr_ok | (bus.ext_wr & ctl_reg[`FESC_BIT_PWE]))
                     & ~(lock_reg & st_page0);
  wire to_ram      = bus.ext_wr & ~ctl_reg[`FESC_BIT_PWE] & ~dbg_wr_ok;
  wire burn_armed  = fuse_reg == `FESC_FUSE_ARM && trim_reg == `FESC_TRIM_BURN;
  wire [7:0] status = {2'h0, pin_reg, 2'h0, fuse1_reg, fuse0_reg, 1'b0};
  wire [7:0] ctl_rd = {1'b0, lock_reg, ctl_reg[5:0]};
  wire [7:0] rd_mux = bus.addr == `FESC_OFF_FLASH_CTL  ? ctl_rd   :
                      bus.addr == `FESC_OFF_PAGE_SEL   ? page_reg :
                      bus.addr == `FESC_OFF_TRIM_CTL   ? trim_reg :
                      bus.addr == `FESC_OFF_FUSE_CTL   ? fsel_reg :
                      bus.addr == `FESC_OFF_SEC_STATUS ? status   : 8'h00;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      fesc_pkg::FESC_IDLE: begin
        if (mass_cpu || mass_dbg) begin
          state_next = fesc_pkg::FESC_MASS;
        end else if (page_go) begin
          state_next = fesc_pkg::FESC_PAGE;
        end
      end
      fesc_pkg::FESC_MASS,
      fesc_pkg::FESC_PAGE: begin
        if (erase_cnt_reg == 8'(`FESC_ERASE_CYCLES - 1)) begin
          state_next = fesc_pkg::FESC_DONE;
        end
      end
      fesc_pkg::FESC_DONE: begin
        state_next = fesc_pkg::FESC_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pin_m_reg <= 1'b0;
      pin_reg   <= 1'b0;
      dbg_m_reg <= 1'b0;
      dbg_reg   <= 1'b0;
    end else begin
      pin_m_reg <= I_SECURITY_PIN;
      pin_reg   <= pin_m_reg;
      dbg_m_reg <= I_DEBUG_PORT_ENABLE;
      dbg_reg   <= dbg_m_reg;
    end
  end

  // Fuses model one-time cells: a real part keeps them across reset, the model
  // keeps them across I_RSTN by not resetting them after first power-up clear.
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_reg          <= fesc_pkg::FESC_IDLE;
      ctl_reg            <= 8'h00;
      page_reg           <= 8'h00;
      trim_reg           <= 8'h00;
      fuse_reg           <= 8'h00;
      fsel_reg           <= 8'h00;
      lock_reg           <= 1'b0;
      strap_done_reg     <= 1'b0;
      fuse1_at_reset_reg <= 1'b1;
      burn_cnt_reg       <= 32'h0;
      erase_cnt_reg      <= 8'h00;
      ack_reg            <= 1'b0;
      dbg_ack_reg        <= 1'b0;
      rdata_reg          <= 8'h00;
    end else begin
      state_reg   <= state_next;
      ack_reg     <= bus.req & ~ack_reg;
      dbg_ack_reg <= bus.dbg_req & ~dbg_ack_reg;
      if (bus.req && !bus.wr && !ack_reg) begin
        rdata_reg <= rd_mux;
      end
      if (!strap_done_reg) begin
        strap_done_reg     <= 1'b1;
        fuse1_at_reset_reg <= fuse1_reg;
      end
      if (wr_ctl) begin
        ctl_reg <= {2'h0, bus.wdata[5:0]};
        if (bus.wdata[`FESC_BIT_LOCK] && fuse0_reg) begin
          lock_reg <= 1'b1;
        end
      end
      if (wr_page) begin
        page_reg <= bus.wdata;
      end
      if (wr_trim) begin
        trim_reg <= bus.wdata;
      end
      if (wr_fuse) begin
        if (bus.wdata == `FESC_FUSE_ARM || bus.wdata == 8'h00) begin
          fuse_reg <= bus.wdata;
          fsel_reg <= 8'h00;
        end else begin
          fsel_reg <= bus.wdata;
        end
      end
      if (!idle) begin
        erase_cnt_reg <= erase_cnt_reg + 8'h01;
      end else begin
        erase_cnt_reg <= 8'h00;
      end
      burn_cnt_reg <= burn_armed ? burn_cnt_reg + 32'h1 : 32'h0;
    end
  end

  // Power-up flag has no reset, so I_RSTN never clears a blown fuse
  logic powered_reg = 1'b0;

  // Blown fuses never return: set only, cleared only on the very first cycle
  always_ff @(posedge I_CLOCK) begin
    powered_reg <= 1'b1;
    if (!powered_reg) begin
      fuse0_reg <= 1'b0;
      fuse1_reg <= 1'b0;
    end else if (burn_armed && burn_cnt_reg == 32'(BURN_CYCLES - 1)) begin
      if (fsel_reg == `FESC_FUSE_SEL0) begin
        fuse0_reg <= 1'b1;
      end
      if (fsel_reg == `FESC_FUSE_SEL1 && pin_reg) begin
        fuse1_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      flash_we_reg   <= 1'b0;
      ram_we_reg     <= 1'b0;
      flash_addr_reg <= '0;
      ram_addr_reg   <= '0;
      flash_data_reg <= 8'h00;
      ram_data_reg   <= 8'h00;
    end else begin
      flash_we_reg   <= to_flash & idle;
      ram_we_reg     <= to_ram;
      flash_addr_reg <= st_addr[ADDR_W-1:0];
      flash_data_reg <= dbg_wr_ok ? bus.dbg_wdata : bus.ext_data;
      ram_addr_reg   <= bus.ext_addr[RAM_W-1:0];
      ram_data_reg   <= bus.ext_data;
    end
  end

  assign bus.ack          = ack_reg;
  assign bus.rdata        = rdata_reg;
  assign bus.dbg_ack      = dbg_ack_reg;
  assign bus.busy         = ~idle;
  assign O_BOOT_VECTOR    = `FESC_RESET_VECTOR;
  assign O_VECTOR_BASE    = `FESC_VECTOR_BASE;
  assign O_DEBUG_PORT_ACTIVE = dbg_ok & ~lock_reg;
  assign O_FLASH_WE       = flash_we_reg;
  assign O_FLASH_ADDR     = flash_addr_reg;
  assign O_FLASH_DATA     = flash_data_reg;
  assign O_RAM_WE         = ram_we_reg;
  assign O_RAM_ADDR       = ram_addr_reg;
  assign O_RAM_DATA       = ram_data_reg;
  // Mass erase flags the flash erase only; nothing here clears data RAM
  assign O_ERASE_MASS     = state_reg == fesc_pkg::FESC_MASS;
  assign O_ERASE_PAGE     = state_reg == fesc_pkg::FESC_PAGE;
  assign O_ERASE_PAGE_NUM = page_reg[7:1];
  assign O_FUSE_BURN      = {fsel_reg == `FESC_FUSE_SEL1 && burn_armed,
                             fsel_reg == `FESC_FUSE_SEL0 && burn_armed};
endmodule // fesc_device
`default_nettype wire

// file: core/fesc_host.sv
// Processor-side controller: APB registers drive function-register accesses
`include "fesc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module fesc_host (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  fesc_if.host             bus
);
  fesc_pkg::fesc_host_t state_reg;
  logic [15:0] addr_reg;
  logic [7:0]  data_reg, rdata_reg;
  logic        wr_reg, dbg_mass_reg, ext_wr_reg;
  wire acc      = PSEL & PENABLE;
  wire hit_ctl  = PADDR == `FESC_APB_CTL;
  wire hit_stat = PADDR == `FESC_APB_STATUS;
  wire hit_addr = PADDR == `FESC_APB_ADDR;
  wire hit_data = PADDR == `FESC_APB_DATA;
  wire hit_rd   = PADDR == `FESC_APB_RDATA;
  wire mapped   = hit_ctl | hit_stat | hit_addr | hit_data | hit_rd;
  wire idle     = state_reg == fesc_pkg::FESC_H_IDLE;
  // Control writes with go (bit0) set start a register access; ready waits for the device ack
  wire start    = acc & PWRITE & hit_ctl & idle & PWDATA[0];
  assign PREADY  = ~(acc & PWRITE & hit_ctl & PWDATA[0]) | state_reg == fesc_pkg::FESC_H_HOLD;
  assign PSLVERR = acc & ~mapped;
  assign PRDATA  = hit_stat ? {30'h0, bus.busy, ~idle} :
                   hit_addr ? {16'h0, addr_reg} :
                   hit_data ? {24'h0, data_reg} :
                   hit_rd   ? {24'h0, rdata_reg} : 32'h0;

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_reg    <= fesc_pkg::FESC_H_IDLE;
      addr_reg     <= 16'h0;
      data_reg     <= 8'h00;
      rdata_reg    <= 8'h00;
      wr_reg       <= 1'b0;
      dbg_mass_reg <= 1'b0;
      ext_wr_reg   <= 1'b0;
    end else begin
      // CTL bit3 with go clear issues one processor store of DATA to ADDR
      ext_wr_reg <= acc & PWRITE & hit_ctl & PWDATA[3] & ~PWDATA[0];
      if (acc && PWRITE && hit_addr) begin
        addr_reg <= PWDATA[15:0];
      end
      if (acc && PWRITE && hit_data) begin
        data_reg <= PWDATA[7:0];
      end
      if (acc && PWRITE && hit_ctl) begin
        dbg_mass_reg <= PWDATA[2];
      end
      unique case (state_reg)
        fesc_pkg::FESC_H_IDLE: begin
          if (start) begin
            wr_reg    <= PWDATA[1];
            state_reg <= fesc_pkg::FESC_H_WAIT;
          end
        end
        fesc_pkg::FESC_H_WAIT: begin
          if (bus.ack) begin
            rdata_reg <= bus.rdata;
            state_reg <= fesc_pkg::FESC_H_HOLD;
          end
        end
        fesc_pkg::FESC_H_HOLD: begin
          state_reg <= fesc_pkg::FESC_H_IDLE;
        end
      endcase
    end
  end

  // Sequences are ordered by software through these writes
  assign bus.req       = state_reg == fesc_pkg::FESC_H_WAIT;
  assign bus.wr        = wr_reg;
  assign bus.addr      = addr_reg;
  assign bus.wdata     = data_reg;
  assign bus.ext_wr    = ext_wr_reg;
  assign bus.ext_addr  = addr_reg;
  assign bus.ext_data  = data_reg;
  assign bus.dbg_req   = dbg_mass_reg;
  assign bus.dbg_wr    = 1'b0;
  assign bus.dbg_mass  = dbg_mass_reg;
  assign bus.dbg_addr  = 16'h0;
  assign bus.dbg_wdata = 8'h00;
endmodule // fesc_host
`default_nettype wire

// file: core/fesc_if.sv
// Function-register bus between the processor-side controller and the flash/security device
`timescale 1ns/1ns
`default_nettype none
interface fesc_if;
  logic        req;
  logic        wr;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        ack;
  logic [7:0]  rdata;
  logic        ext_wr;
  logic [15:0] ext_addr;
  logic [7:0]  ext_data;
  logic        dbg_req;
  logic        dbg_wr;
  logic        dbg_mass;
  logic [15:0] dbg_addr;
  logic [7:0]  dbg_wdata;
  logic        dbg_ack;
  logic        busy;
  modport dev  (input req, wr, addr, wdata, ext_wr, ext_addr, ext_data,
                dbg_req, dbg_wr, dbg_mass, dbg_addr, dbg_wdata,
                output ack, rdata, dbg_ack, busy);
  modport host (output req, wr, addr, wdata, ext_wr, ext_addr, ext_data,
                dbg_req, dbg_wr, dbg_mass, dbg_addr, dbg_wdata,
                input ack, rdata, dbg_ack, busy);
endinterface
`default_nettype wire

// file: core/fesc_params.svh
// Register offsets, field positions, command patterns and timing counts for flash/security control
`ifndef FESC_PARAMS_SVH
`define FESC_PARAMS_SVH
`define FESC_OFF_ERASE_CMD     16'h0094
`define FESC_OFF_FLASH_CTL     16'h00B2
`define FESC_OFF_PAGE_SEL      16'h00B7
`define FESC_OFF_TRIM_CTL      16'hFFD1
`define FESC_OFF_FUSE_CTL      16'hFFD2
`define FESC_OFF_SEC_STATUS    16'hFFD7
`define FESC_BIT_PWE           0
`define FESC_BIT_MEEN          1
`define FESC_BIT_LOCK          6
`define FESC_BIT_FUSE0         1
`define FESC_BIT_FUSE2         2
`define FESC_BIT_PIN           5
`define FESC_PAT_MASS          8'hAA
`define FESC_PAT_PAGE          8'h55
`define FESC_FUSE_ARM          8'h54
`define FESC_FUSE_SEL0         8'h81
`define FESC_FUSE_SEL1         8'h82
`define FESC_TRIM_BURN         8'hA6
`define FESC_CLK_SETTING       8'h0C
`define FESC_RESET_VECTOR      16'h0000
`define FESC_VECTOR_BASE       16'h0003
`define FESC_VECTOR_STEP       16'h0008
`define FESC_BURN_US           500
`define FESC_CLK_MHZ           50
`define FESC_BURN_CYCLES       (`FESC_BURN_US * `FESC_CLK_MHZ)
`define FESC_ERASE_CYCLES      64
`define FESC_APB_CTL           12'h000
`define FESC_APB_STATUS        12'h004
`define FESC_APB_ADDR          12'h008
`define FESC_APB_DATA          12'h00C
`define FESC_APB_RDATA         12'h010
`endif

// file: core/fesc_pkg.sv
// Types shared by the flash/security controller ends
package fesc_pkg;
  typedef enum logic [3:0] {
    FESC_IDLE  = 4'b0001,
    FESC_MASS  = 4'b0010,
    FESC_PAGE  = 4'b0100,
    FESC_DONE  = 4'b1000
  } fesc_erase_t;
  typedef enum logic [2:0] {
    FESC_H_IDLE  = 3'b001,
    FESC_H_WAIT  = 3'b010,
    FESC_H_HOLD  = 3'b100
  } fesc_host_t;
endpackage

// file: dv/fesc_chk.sv
// Concurrent checks on the device request bus and the erase and fuse outputs
`include "fesc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module fesc_chk (
  input wire logic        I_CLOCK,
  input wire logic        I_RSTN,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        ack,
  input wire logic        busy,
  input wire logic        I_DEBUG_PORT_ENABLE,
  input wire logic        O_ERASE_MASS,
  input wire logic        O_ERASE_PAGE,
  input wire logic [1:0]  O_FUSE_BURN,
  input wire logic [15:0] O_BOOT_VECTOR,
  input wire logic [15:0] O_VECTOR_BASE
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  wire        cmd_wr   = req && !ack && wr && (addr == `FESC_OFF_ERASE_CMD);
  wire        page_cmd = cmd_wr && (wdata == `FESC_PAT_PAGE);
  wire        mass_cmd = cmd_wr && (wdata == `FESC_PAT_MASS);
  wire        erasing  = O_ERASE_MASS || O_ERASE_PAGE;
  logic [7:0] run_cnt;
  // Length counted here because a 64-cycle repetition is too costly to unroll
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) run_cnt <= 8'h00;
    else if (erasing) run_cnt <= run_cnt + 8'h01;
    else run_cnt <= 8'h00;
  end
  property p_ack_next; req && !ack |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");
  property p_page_cause; $rose(O_ERASE_PAGE) |-> $past(page_cmd) || $past(page_cmd, 2); endproperty
  a_page_cause: assert property (p_page_cause) else $error("page erase without command");
  property p_mass_cause; $rose(O_ERASE_MASS) |-> $past(mass_cmd) || $past(mass_cmd, 2); endproperty
  a_mass_cause: assert property (p_mass_cause) else $error("mass erase without command");
  property p_mass_dbg; $rose(O_ERASE_MASS) |-> $past(I_DEBUG_PORT_ENABLE, 3); endproperty
  a_mass_dbg: assert property (p_mass_dbg) else $error("mass erase with debug port off");
  property p_erase_len; $fell(erasing) |-> run_cnt == 8'h40; endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
  property p_busy; erasing |-> busy && !(O_ERASE_MASS && O_ERASE_PAGE); endproperty
  a_busy: assert property (p_busy) else $error("erase not flagged busy");
  property p_vec; O_BOOT_VECTOR == 16'h0000 && O_VECTOR_BASE == 16'h0003; endproperty
  a_vec: assert property (p_vec) else $error("vector outputs wrong");
  property p_one_fuse; $onehot0(O_FUSE_BURN); endproperty
  a_one_fuse: assert property (p_one_fuse) else $error("two fuses burning");
  c_page: cover property (page_cmd ##[1:2] O_ERASE_PAGE);
  c_mass: cover property ($rose(O_ERASE_MASS));
  c_fuse: cover property (O_FUSE_BURN == 2'b01);
endmodule // fesc_chk
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench: APB-driven controller facing the flash/security device
`include "fesc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        I_CLOCK, I_RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, pin, dbg_en, dbg_act;
  logic        e_mass, e_page, err, fwe, rwe;
  logic [14:0] faddr;
  logic [10:0] raddr;
  logic [7:0]  fdata, rdat;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r32;
  logic [6:0]  page_num;
  logic [1:0]  fuse_burn;
  logic [15:0] boot_vec, vec_base;
  logic [7:0]  rd, pg, v;
  int          n_fail, tests_run, lock_m, fuse0_m;
  fesc_if i_fesc_if ();
  fesc_host i_fesc_host (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .bus(i_fesc_if.host));
  fesc_device #(.BURN_CYCLES(10)) i_fesc_device (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN),
    .bus(i_fesc_if.dev), .I_SECURITY_PIN(pin), .I_DEBUG_PORT_ENABLE(dbg_en),
    .O_BOOT_VECTOR(boot_vec), .O_VECTOR_BASE(vec_base), .O_DEBUG_PORT_ACTIVE(dbg_act),
    .O_FLASH_WE(fwe), .O_FLASH_ADDR(faddr), .O_FLASH_DATA(fdata), .O_RAM_WE(rwe),
    .O_RAM_ADDR(raddr), .O_RAM_DATA(rdat), .O_ERASE_MASS(e_mass), .O_ERASE_PAGE(e_page),
    .O_ERASE_PAGE_NUM(page_num), .O_FUSE_BURN(fuse_burn));
  fesc_chk i_fesc_chk (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .req(i_fesc_if.req),
    .wr(i_fesc_if.wr), .addr(i_fesc_if.addr), .wdata(i_fesc_if.wdata), .ack(i_fesc_if.ack),
    .busy(i_fesc_if.busy), .I_DEBUG_PORT_ENABLE(dbg_en), .O_ERASE_MASS(e_mass),
    .O_ERASE_PAGE(e_page), .O_FUSE_BURN(fuse_burn), .O_BOOT_VECTOR(boot_vec),
    .O_VECTOR_BASE(vec_base));
  initial begin
    I_CLOCK = 1'b0;
    forever #10 I_CLOCK = ~I_CLOCK;
  end
  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Read just after the edge, the slave's outputs still show what that edge sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge I_CLOCK);
    PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge I_CLOCK);
    PENABLE <= 1'b1;
    n = 0;
    do begin @(posedge I_CLOCK); n++; end while (PREADY !== 1'b1 && n < 500);
    if (n >= 500) chk(8'h01, 8'h00);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask
  // One processor store; flash or RAM strobe expected as the write enable and lock say
  task automatic st_chk(input logic [15:0] a, input logic [7:0] d, input logic ef,
                        input logic er);
    logic        sf, sr;
    logic [14:0] ga;
    logic [7:0]  gd;
    int          n;
    sf = 1'b0; sr = 1'b0; ga = 15'h0000; gd = 8'h00;
    apb(1'b1, `FESC_APB_ADDR, {16'h0000, a}, r32, err);
    apb(1'b1, `FESC_APB_DATA, {24'h000000, d}, r32, err);
    apb(1'b1, `FESC_APB_CTL, 32'h00000008, r32, err);
    for (n = 0; n < 4; n++) begin
      @(negedge I_CLOCK);
      if (fwe === 1'b1) begin sf = 1'b1; ga = faddr; gd = fdata; end
      if (rwe === 1'b1) begin sr = 1'b1; ga = {4'h0, raddr}; gd = rdat; end
    end
    chk({7'h00, sf}, {7'h00, ef});
    chk({7'h00, sr}, {7'h00, er});
    if (sf || sr) chk(gd, d);
    if (sf || sr) chk(ga[7:0], a[7:0]);
  endtask
  task automatic fr_wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, `FESC_APB_ADDR, {16'h0000, a}, r32, err);
    apb(1'b1, `FESC_APB_DATA, {24'h000000, d}, r32, err);
    apb(1'b1, `FESC_APB_CTL, 32'h00000003, r32, err);
    if (a == `FESC_OFF_FLASH_CTL && d[6] && fuse0_m != 0) lock_m = 1;
  endtask
  task automatic fr_rd(input logic [15:0] a, output logic [7:0] d);
    apb(1'b1, `FESC_APB_ADDR, {16'h0000, a}, r32, err);
    apb(1'b1, `FESC_APB_CTL, 32'h00000001, r32, err);
    apb(1'b0, `FESC_APB_RDATA, 32'h00000000, r32, err);
    d = r32[7:0];
  endtask
  // Waits out any erase so the next command never lands in a busy device
  task automatic erase_chk(input logic em, input logic ep, input logic [6:0] p);
    logic sm, sp;
    int   n;
    sm = 1'b0; sp = 1'b0;
    for (n = 0; n < 8; n++) begin
      @(negedge I_CLOCK);
      sm = sm | e_mass;
      sp = sp | e_page;
    end
    chk({7'h00, sm}, {7'h00, em});
    chk({7'h00, sp}, {7'h00, ep});
    if (sp === 1'b1) chk({1'b0, page_num}, {1'b0, p});
    n = 0;
    while ((e_mass | e_page) !== 1'b0 && n < 200) begin @(negedge I_CLOCK); n++; end
  endtask
  initial begin
    I_RSTN = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 12'h000;
    PWDATA = 32'h00000000; dbg_en = 1'b0;
    n_fail = 0; tests_run = 0; lock_m = 0; fuse0_m = 0;
    // Core clock setting and interrupt masking live outside this block; taken as done
    r32 = $urandom(32'h74ED);
    pin = 1'($urandom);
    repeat (6) @(posedge I_CLOCK);
    I_RSTN <= 1'b1;
    repeat (2) @(posedge I_CLOCK);
    fr_rd(`FESC_OFF_FLASH_CTL, rd); chk({7'h00, rd[6]}, 8'(lock_m));
    fr_rd(`FESC_OFF_SEC_STATUS, rd); chk({6'h00, rd[5], rd[1]}, {6'h00, pin, 1'b0});
    apb(1'b0, 12'h020, 32'h00000000, r32, err); chk({7'h00, err}, 8'h01);
    pg = 8'($urandom);
    fr_wr(`FESC_OFF_PAGE_SEL, pg); fr_wr(`FESC_OFF_ERASE_CMD, `FESC_PAT_PAGE);
    erase_chk(1'b0, 1'b1, pg[7:1]);
    repeat (3) begin
      v = 8'($urandom);
      if (v == `FESC_PAT_MASS || v == `FESC_PAT_PAGE) v = 8'h12;
      fr_wr(`FESC_OFF_ERASE_CMD, v); erase_chk(1'b0, 1'b0, 7'h00);
    end
    fr_wr(`FESC_OFF_FLASH_CTL, 8'h00); fr_wr(`FESC_OFF_ERASE_CMD, `FESC_PAT_MASS);
    erase_chk(1'b0, 1'b0, 7'h00);
    fr_wr(`FESC_OFF_FLASH_CTL, 8'h02); fr_wr(`FESC_OFF_ERASE_CMD, `FESC_PAT_MASS);
    erase_chk(1'b0, 1'b0, 7'h00);
    dbg_en <= 1'b1;
    fr_wr(`FESC_OFF_FLASH_CTL, 8'h02); fr_wr(`FESC_OFF_ERASE_CMD, `FESC_PAT_MASS);
    erase_chk(1'b1, 1'b0, 7'h00);
    st_chk(16'h0123, 8'($urandom), 1'b0, 1'b1);
    fr_wr(`FESC_OFF_FLASH_CTL, 8'h01);
    st_chk(16'h0234, 8'h5A, 1'b1, 1'b0);
    fr_wr(`FESC_OFF_FLASH_CTL, 8'h40); fr_rd(`FESC_OFF_FLASH_CTL, rd);
    chk({7'h00, rd[6]}, 8'(lock_m));
    fr_wr(`FESC_OFF_FUSE_CTL, `FESC_FUSE_ARM); fr_wr(`FESC_OFF_FUSE_CTL, `FESC_FUSE_SEL0);
    fr_wr(`FESC_OFF_TRIM_CTL, `FESC_TRIM_BURN);
    @(negedge I_CLOCK); chk({6'h00, fuse_burn}, 8'h01);
    repeat (20) @(posedge I_CLOCK);
    fr_wr(`FESC_OFF_TRIM_CTL, 8'h00); fr_wr(`FESC_OFF_FUSE_CTL, 8'h00);
    fuse0_m = 1;
    @(negedge I_CLOCK); chk({6'h00, fuse_burn}, 8'h00);
    fr_rd(`FESC_OFF_SEC_STATUS, rd); chk({7'h00, rd[1]}, 8'(fuse0_m));
    fr_wr(`FESC_OFF_FLASH_CTL, 8'h40); fr_wr(`FESC_OFF_FLASH_CTL, 8'h00);
    fr_rd(`FESC_OFF_FLASH_CTL, rd); chk({7'h00, rd[6]}, 8'(lock_m));
    chk({7'h00, dbg_act}, 8'(1 - lock_m));
    fr_wr(`FESC_OFF_FLASH_CTL, 8'h01);
    st_chk(16'h0010, 8'hC3, 1'b0, 1'b0);
    st_chk(16'h0210, 8'h3C, 1'b1, 1'b0);
    fr_wr(`FESC_OFF_PAGE_SEL, 8'h01); fr_wr(`FESC_OFF_ERASE_CMD, `FESC_PAT_PAGE);
    erase_chk(1'b0, 1'b0, 7'h00);
    fr_wr(`FESC_OFF_PAGE_SEL, 8'h02); fr_wr(`FESC_OFF_ERASE_CMD, `FESC_PAT_PAGE);
    erase_chk(1'b0, 1'b1, 7'h01);
    I_RSTN <= 1'b0;
    lock_m = 0;
    repeat (3) @(posedge I_CLOCK);
    I_RSTN <= 1'b1;
    repeat (2) @(posedge I_CLOCK);
    fr_rd(`FESC_OFF_FLASH_CTL, rd); chk({7'h00, rd[6]}, 8'(lock_m));
    fr_rd(`FESC_OFF_SEC_STATUS, rd); chk({7'h00, rd[1]}, 8'(fuse0_m));
    chk({7'h00, dbg_act}, 8'h01);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge I_CLOCK);
    n_fail++;
    end_sim();
  end
endmodule // tb
`default_nettype wire
